//--- rtl/gpio_pkg.sv
// Package with register map, reset values, pin bundles and bus request types of the parallel ports.
// Overview of operation
// - Outputs are latched, inputs are not; external sources hold input data until read.
// - A port read samples the live pin levels in the S1 state of the read; here only the pin registers do, and a port 1 read returns its latch.
// - A port write changes the driven output in the S2 state of the write.
// - Reset sets port 0 latch to all ones and drive select to all zeros.
// - Port 0 drive select 0 gives open-drain output, 1 gives push-pull output.
// - Port 0 latch register reads the latch; the pin register reads live pin levels.
// - Port 1 is three bits with direction; reset clears direction and latch to 0.
// - Port 1 bit 1 raises its interrupt request on either edge, even as output.
// - Port 1 bit 0 is port or interrupt input by select bit; port after reset.
// - Reset sets port 2 latch to ones; software keeps it 1 for inputs.
// - Port 2 bits 1 and 2 are resonator pins in dual-clock mode, else plain I/O.
// - Port 2 bit 0 raises its interrupt request on a falling edge, even as output.
// - Port 2 has a latch register and a separate live pin register.
// - Port 2 register bits 7 to 3 are undefined on read; this block returns zero.
// - In STOP mode port 2 bit 0 floats regardless of its output enable.
// - Interrupt 0 select 0 gives port operation on port 1 bit 0, 1 gives interrupt.
package gpio_pkg;

  // ==========================================================================
  // Register map
  localparam logic [5:0] PORT0_OUTPUT_LATCH_ADDR = 6'h00;
  localparam logic [5:0] PORT1_OUTPUT_LATCH_ADDR = 6'h01;
  localparam logic [5:0] PORT2_OUTPUT_LATCH_ADDR = 6'h02;
  localparam logic [5:0] PORT1_DIRECTION_ADDR    = 6'h09;
  localparam logic [5:0] PORT0_DRIVE_SELECT_ADDR = 6'h0b;
  localparam logic [5:0] PORT0_PIN_LEVEL_ADDR    = 6'h0c;
  localparam logic [5:0] PORT2_PIN_LEVEL_ADDR    = 6'h0d;

  // ==========================================================================
  // Port widths and reset values
  localparam int         PORT0_WIDTH = 8;
  localparam int         PORT1_WIDTH = 3;
  localparam int         PORT2_WIDTH = 3;

  localparam logic [7:0] PORT0_LATCH_RESET     = 8'hff;
  localparam logic [7:0] PORT0_DRIVE_SEL_RESET = 8'h00;
  localparam logic [2:0] PORT1_LATCH_RESET     = 3'h0;
  localparam logic [2:0] PORT1_DIR_RESET       = 3'h0;
  localparam logic [2:0] PORT2_LATCH_RESET     = 3'h7;
  localparam logic [7:0] READ_ZERO             = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int PORT1_IRQ0_BIT      = 0;
  localparam int PORT1_IRQ1_BIT      = 1;
  localparam int PORT2_IRQ_BIT       = 0;
  localparam int PORT2_RES_IN_BIT    = 1;
  localparam int PORT2_RES_OUT_BIT   = 2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       rd_s1;
    logic       wr_s2;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } port0_drive_type;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } port3_drive_type;

endpackage

//--- rtl/parallel_io_ports.sv
// Parallel I/O ports 0 to 2: latches, direction and drive control, pin reads and edge requests.
`timescale 1ns/1ps
module parallel_io_ports (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  // CPU special-function access
  input  wire gpio_pkg::sfr_req_type     sfr_req,
  output logic [7:0]                     sfr_rdata,
  output logic                           sfr_rvalid,
  output logic                           sfr_hit,
  // Mode inputs from system control
  input  wire logic                      ext_irq0_pin_select,
  input  wire logic                      dual_clock_mode,
  input  wire logic                      stop_mode,
  // Port 0 pins
  input  wire logic [7:0]                port0_pin_in,
  output gpio_pkg::port0_drive_type      port0_pin,
  // Port 1 pins
  input  wire logic [2:0]                port1_pin_in,
  output gpio_pkg::port3_drive_type      port1_pin,
  // Port 2 pins
  input  wire logic [2:0]                port2_pin_in,
  output gpio_pkg::port3_drive_type      port2_pin,
  // Low-frequency resonator connection
  input  wire logic                      slow_resonator_out,
  output logic                           slow_resonator_in,
  // Interrupt requests to the interrupt controller
  output logic                           ext_irq0_req,
  output logic                           port1_bit1_irq_req,
  output logic                           port2_bit0_irq_req
);

  // ==========================================================================
  // Register state
  logic [7:0] port0_output_latch_q;
  logic [7:0] port0_output_latch_d;
  logic [7:0] port0_drive_select_q;
  logic [7:0] port0_drive_select_d;
  logic [2:0] port1_output_latch_q;
  logic [2:0] port1_output_latch_d;
  logic [2:0] port1_direction_q;
  logic [2:0] port1_direction_d;
  logic [2:0] port2_output_latch_q;
  logic [2:0] port2_output_latch_d;

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  logic       addr_mapped;
  logic       addr_writable;

  // ==========================================================================
  // Address decode
  // Reserved and foreign addresses are simply not claimed; the hit flag lets
  // the surrounding register mux pick another block's answer.
  always_comb begin
    addr_mapped   = 1'b0;
    addr_writable = 1'b0;
    unique case (sfr_req.addr)
      gpio_pkg::PORT0_OUTPUT_LATCH_ADDR,
      gpio_pkg::PORT1_OUTPUT_LATCH_ADDR,
      gpio_pkg::PORT2_OUTPUT_LATCH_ADDR,
      gpio_pkg::PORT1_DIRECTION_ADDR,
      gpio_pkg::PORT0_DRIVE_SELECT_ADDR: begin
        addr_mapped   = 1'b1;
        addr_writable = 1'b1;
      end
      gpio_pkg::PORT0_PIN_LEVEL_ADDR,
      gpio_pkg::PORT2_PIN_LEVEL_ADDR: begin
        addr_mapped   = 1'b1;
      end
      default: begin
        addr_mapped   = 1'b0;
      end
    endcase
  end

  assign sfr_hit = addr_mapped && (sfr_req.rd_s1 || sfr_req.wr_s2);

  // ==========================================================================
  // Output latches and control registers
  // The write strobe marks the S2 state of the write cycle; the latch takes
  // the new value on that edge, and the pins follow it on that same edge.
  always_comb begin
    port0_output_latch_d = port0_output_latch_q;
    port0_drive_select_d = port0_drive_select_q;
    port1_output_latch_d = port1_output_latch_q;
    port1_direction_d    = port1_direction_q;
    port2_output_latch_d = port2_output_latch_q;
    if (sfr_req.wr_s2 && addr_writable) begin
      unique case (sfr_req.addr)
        gpio_pkg::PORT0_OUTPUT_LATCH_ADDR: begin
          port0_output_latch_d = sfr_req.wdata;
        end
        gpio_pkg::PORT1_OUTPUT_LATCH_ADDR: begin
          port1_output_latch_d = sfr_req.wdata[2:0];
        end
        gpio_pkg::PORT2_OUTPUT_LATCH_ADDR: begin
          port2_output_latch_d = sfr_req.wdata[2:0];
        end
        gpio_pkg::PORT1_DIRECTION_ADDR: begin
          port1_direction_d = sfr_req.wdata[2:0];
        end
        gpio_pkg::PORT0_DRIVE_SELECT_ADDR: begin
          port0_drive_select_d = sfr_req.wdata;
        end
        default: begin
          port0_output_latch_d = port0_output_latch_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port0_output_latch_q <= gpio_pkg::PORT0_LATCH_RESET;
      port0_drive_select_q <= gpio_pkg::PORT0_DRIVE_SEL_RESET;
      port1_output_latch_q <= gpio_pkg::PORT1_LATCH_RESET;
      port1_direction_q    <= gpio_pkg::PORT1_DIR_RESET;
      port2_output_latch_q <= gpio_pkg::PORT2_LATCH_RESET;
    end else begin
      port0_output_latch_q <= port0_output_latch_d;
      port0_drive_select_q <= port0_drive_select_d;
      port1_output_latch_q <= port1_output_latch_d;
      port1_direction_q    <= port1_direction_d;
      port2_output_latch_q <= port2_output_latch_d;
    end
  end

  // ==========================================================================
  // Read path
  // Pins are not latched: the read strobe marks S1 of the read cycle, and the
  // live level present on that edge is what software sees.
  // The unused upper bits of the 3-bit ports read as zero. A fixed value is
  // easier to test than whatever the bus would otherwise float to.
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = sfr_req.rd_s1;
    if (sfr_req.rd_s1) begin
      rdata_d = gpio_pkg::READ_ZERO;
      unique case (sfr_req.addr)
        gpio_pkg::PORT0_OUTPUT_LATCH_ADDR: begin
          rdata_d = port0_output_latch_q;
        end
        gpio_pkg::PORT1_OUTPUT_LATCH_ADDR: begin
          rdata_d = {5'h00, port1_output_latch_q};
        end
        gpio_pkg::PORT2_OUTPUT_LATCH_ADDR: begin
          rdata_d = {5'h00, port2_output_latch_q};
        end
        gpio_pkg::PORT1_DIRECTION_ADDR: begin
          rdata_d = {5'h00, port1_direction_q};
        end
        gpio_pkg::PORT0_DRIVE_SELECT_ADDR: begin
          rdata_d = port0_drive_select_q;
        end
        gpio_pkg::PORT0_PIN_LEVEL_ADDR: begin
          rdata_d = port0_pin_in;
        end
        gpio_pkg::PORT2_PIN_LEVEL_ADDR: begin
          rdata_d = {5'h00, port2_pin_in};
        end
        default: begin
          rdata_d = gpio_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q  <= gpio_pkg::READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign sfr_rdata  = rdata_q;
  assign sfr_rvalid = rvalid_q;

  // ==========================================================================
  // Port 0 output stage
  // Open-drain bits only ever pull low; a latch bit of 1 releases the pin so
  // an external driver or pull-up decides the level.
  generate
    for (genvar b = 0; b < gpio_pkg::PORT0_WIDTH; b++) begin : g_port0
      always_comb begin
        if (port0_drive_select_q[b]) begin
          port0_pin.out[b] = port0_output_latch_q[b];
          port0_pin.oe[b]  = 1'b1;
        end else begin
          port0_pin.out[b] = 1'b0;
          port0_pin.oe[b]  = !port0_output_latch_q[b];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Port 1 output stage
  // With the interrupt 0 select set, bit 0 becomes an interrupt input and is
  // never driven, even if its direction bit was left at 1.
  generate
    for (genvar b = 0; b < gpio_pkg::PORT1_WIDTH; b++) begin : g_port1
      always_comb begin
        port1_pin.out[b] = port1_output_latch_q[b];
        port1_pin.oe[b]  = port1_direction_q[b];
        if ((b == gpio_pkg::PORT1_IRQ0_BIT) && ext_irq0_pin_select) begin
          port1_pin.oe[b] = 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Port 2 output stage
  // Port 2 drives low only, released by a latch bit of 1. In dual-clock mode
  // bits 1 and 2 belong to the resonator; the oscillator amplifier output is
  // passed onto bit 2 and bit 1 is left undriven as the resonator input.
  generate
    for (genvar b = 0; b < gpio_pkg::PORT2_WIDTH; b++) begin : g_port2
      always_comb begin
        port2_pin.out[b] = 1'b0;
        port2_pin.oe[b]  = !port2_output_latch_q[b];
        if (dual_clock_mode && (b == gpio_pkg::PORT2_RES_OUT_BIT)) begin
          port2_pin.out[b] = slow_resonator_out;
          port2_pin.oe[b]  = 1'b1;
        end else if (dual_clock_mode && (b == gpio_pkg::PORT2_RES_IN_BIT)) begin
          port2_pin.oe[b] = 1'b0;
        end else if (stop_mode && (b == gpio_pkg::PORT2_IRQ_BIT)) begin
          port2_pin.oe[b] = 1'b0;
        end
      end
    end
  endgenerate

  assign slow_resonator_in = dual_clock_mode && port2_pin_in[gpio_pkg::PORT2_RES_IN_BIT];

  // ==========================================================================
  // Edge requests
  // Edges are taken from the pin input, not from the latch, so a pin that the
  // port itself drives still raises its request when the level changes.
  // The flip side is that rewriting the latch or direction of such a pin can
  // raise a request of its own, so software masks the request around the change.
  logic irq0_fall;
  logic p11_rise;
  logic p11_fall;
  logic p20_fall;

  pin_edge_detect u_edge_p10 (
    .ref_clk (ref_clk),
    .srst    (srst),
    .level   (port1_pin_in[gpio_pkg::PORT1_IRQ0_BIT]),
    .rise    (),
    .fall    (irq0_fall)
  );

  pin_edge_detect u_edge_p11 (
    .ref_clk (ref_clk),
    .srst    (srst),
    .level   (port1_pin_in[gpio_pkg::PORT1_IRQ1_BIT]),
    .rise    (p11_rise),
    .fall    (p11_fall)
  );

  pin_edge_detect u_edge_p20 (
    .ref_clk (ref_clk),
    .srst    (srst),
    .level   (port2_pin_in[gpio_pkg::PORT2_IRQ_BIT]),
    .rise    (),
    .fall    (p20_fall)
  );

  assign ext_irq0_req       = irq0_fall && ext_irq0_pin_select;
  assign port1_bit1_irq_req = p11_rise || p11_fall;
  assign port2_bit0_irq_req = p20_fall;

endmodule

//--- rtl/pin_edge_detect.sv
// Single-pin edge detector producing registered rise and fall pulses.
`timescale 1ns/1ps
module pin_edge_detect (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Pin level
  input  wire logic level,
  // Edge pulses
  output logic      rise,
  output logic      fall
);

  logic prev_q;
  logic prev_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;
  logic armed_q;
  logic armed_d;

  // ==========================================================================
  // Edge history
  // The first sample after reset only arms the detector, so a pin that sits
  // high out of reset does not look like a rising edge.
  always_comb begin
    prev_d  = level;
    armed_d = 1'b1;
    rise_d  = armed_q && !prev_q && level;
    fall_d  = armed_q && prev_q && !level;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      armed_q <= armed_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

  assign rise = rise_q;
  assign fall = fall_q;

endmodule

//--- sim/parallel_io_ports_p0_p2_tb.sv
// Self-checking bench for the parallel port block.
`timescale 1ns/1ps
module parallel_io_ports_p0_p2_tb;
  typedef struct packed {logic wr; logic [5:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  logic                      ref_clk = 1'b0;
  logic                      srst = 1'b1;
  gpio_pkg::sfr_req_type     sfr_req = '0;
  logic                      sel = 1'b0, dual = 1'b0, stop = 1'b0, res_out = 1'b0, clr_n = 1'b0;
  logic [7:0]                ext0 = 8'h00, lvl0, got_q;
  logic [2:0]                ext1 = 3'h7, ext2 = 3'h7, lvl1, lvl2;
  logic                      rvalid, hit, res_in, irq0, irq1, irq2;
  gpio_pkg::port0_drive_type p0;
  gpio_pkg::port3_drive_type p1, p2;
  int                        bad_count = 0, num_checks = 0, n0 = 0, n1 = 0, n2 = 0;
  row_type rows [0:8] = '{{1'b1, 6'h00, 8'h5a, 8'h5a}, {1'b1, 6'h01, 8'hff, 8'h07}, {1'b1, 6'h02, 8'hf2, 8'h02},
    {1'b1, 6'h09, 8'h06, 8'h06}, {1'b1, 6'h0b, 8'h0f, 8'h0f}, {1'b1, 6'h03, 8'haa, 8'h00},
    {1'b1, 6'h0c, 8'hff, 8'h0a}, {1'b1, 6'h0d, 8'h00, 8'h02}, {1'b0, 6'h00, 8'h00, 8'h5a}};
  row_type rst_rows [0:4] = '{{1'b0, 6'h00, 8'h00, 8'hff}, {1'b0, 6'h01, 8'h00, 8'h00},
    {1'b0, 6'h02, 8'h00, 8'h07}, {1'b0, 6'h09, 8'h00, 8'h00}, {1'b0, 6'h0b, 8'h00, 8'h00}};

  parallel_io_ports u_dut (.ref_clk(ref_clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(got_q), .sfr_rvalid(rvalid),
    .sfr_hit(hit), .ext_irq0_pin_select(sel), .dual_clock_mode(dual), .stop_mode(stop), .port0_pin_in(lvl0),
    .port0_pin(p0), .port1_pin_in(lvl1), .port1_pin(p1), .port2_pin_in(lvl2), .port2_pin(p2),
    .slow_resonator_out(res_out), .slow_resonator_in(res_in), .ext_irq0_req(irq0), .port1_bit1_irq_req(irq1),
    .port2_bit0_irq_req(irq2));
  pin_world u_world (.port0_pin(p0), .port1_pin(p1), .port2_pin(p2), .ext0(ext0), .ext1(ext1), .ext2(ext2),
    .lvl0(lvl0), .lvl1(lvl1), .lvl2(lvl2));

  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n0 = clr_n ? 0 : n0 + int'(irq0 === 1'b1);
    n1 = clr_n ? 0 : n1 + int'(irq1 === 1'b1);
    n2 = clr_n ? 0 : n2 + int'(irq2 === 1'b1);
  end

  // ==========
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_req = '{1'b0, 1'b1, a, d};
    @(negedge ref_clk);
    sfr_req.wr_s2 = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    sfr_req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge ref_clk);
    sfr_req.rd_s1 = 1'b0;
    v = got_q;
    chk({7'h00, rvalid}, 8'h01);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========
  // Tests
  initial begin
    logic [7:0] v;
    idle(3);
    srst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    $display("register rows done");
    @(negedge ref_clk);
    sfr_req = '{1'b1, 1'b0, 6'h0c, 8'h00};
    ext0 = 8'hff;
    @(negedge ref_clk);
    sfr_req.rd_s1 = 1'b0;
    ext0 = 8'h00;
    chk(got_q, 8'h5a);
    idle(1);
    chk(got_q, 8'h5a);
    rd(6'h0c, v);
    chk(v, 8'h0a);
    $display("pin sampling done");
    ext0 = 8'hff;
    wr(6'h00, 8'h00);
    chk(lvl0, 8'h00);
    wr(6'h00, 8'hff);
    chk(lvl0, 8'hff);
    wr(6'h0b, 8'h00);
    chk(p0.oe, 8'h00);
    $display("port 0 drive done");
    wr(6'h02, 8'h07);
    idle(3);
    clr_n = 1'b1;
    idle(1);
    clr_n = 1'b0;
    wr(6'h01, 8'h05);
    wr(6'h01, 8'h07);
    ext1[0] = 1'b0;
    idle(2);
    ext1[0] = 1'b1;
    sel = 1'b1;
    idle(2);
    ext1[0] = 1'b0;
    wr(6'h02, 8'h06);
    wr(6'h02, 8'h07);
    idle(3);
    chk(8'(n1), 8'h02);
    chk(8'(n0), 8'h01);
    chk(8'(n2), 8'h01);
    sel = 1'b0;
    wr(6'h09, 8'h07);
    chk({5'h00, p1.oe}, 8'h07);
    $display("edge requests done");
    wr(6'h02, 8'h06);
    stop = 1'b1;
    idle(1);
    chk({7'h00, p2.oe[0]}, 8'h00);
    stop = 1'b0;
    dual = 1'b1;
    res_out = 1'b1;
    ext2[1] = 1'b0;
    idle(1);
    chk({5'h00, p2.oe[2], p2.out[2], res_in}, 8'h06);
    $display("stop and resonator done");
    srst = 1'b1;
    idle(1);
    srst = 1'b0;
    dual = 1'b0;
    chk(p0.oe, 8'h00);
    foreach (rst_rows[i]) begin
      rd(rst_rows[i].a, v);
      chk(v, rst_rows[i].e);
    end
    $display("reset values done");
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end
endmodule

//--- sim/parallel_io_ports_properties.sv
// Concurrent checks on the parallel port block, bound to its ports.
`timescale 1ns/1ps
module parallel_io_ports_properties (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      srst,
  // Bus
  input wire gpio_pkg::sfr_req_type     sfr_req,
  input wire logic [7:0]                sfr_rdata,
  input wire logic                      sfr_rvalid,
  input wire logic                      sfr_hit,
  // Modes
  input wire logic                      ext_irq0_pin_select,
  input wire logic                      dual_clock_mode,
  input wire logic                      stop_mode,
  // Pins
  input wire logic [7:0]                port0_pin_in,
  input wire gpio_pkg::port0_drive_type port0_pin,
  input wire logic [2:0]                port1_pin_in,
  input wire gpio_pkg::port3_drive_type port1_pin,
  input wire logic [2:0]                port2_pin_in,
  input wire gpio_pkg::port3_drive_type port2_pin,
  input wire logic                      slow_resonator_out,
  input wire logic                      slow_resonator_in,
  // Requests
  input wire logic                      ext_irq0_req,
  input wire logic                      port1_bit1_irq_req,
  input wire logic                      port2_bit0_irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Edge detectors need two clean samples after reset before a pulse is owed.
  logic [1:0] run_q;
  logic [1:0] run_d;
  always_comb run_d = {run_q[0], ~srst};
  always_ff @(posedge ref_clk) run_q <= run_d;
  sequence wr_s(logic [5:0] a);
    sfr_req.wr_s2 && sfr_req.addr == a;
  endsequence
  sequence fall0_s;
    run_q == 2'b11 && $fell(port1_pin_in[0]) ##1 ext_irq0_pin_select;
  endsequence
  // ==========
  // Properties
  rd_valid_a: assert property (sfr_req.rd_s1 |=> sfr_rvalid)
    else $error("read gave no valid pulse");
  p0_level_a: assert property (sfr_req.rd_s1 && sfr_req.addr == 6'h0c |=> sfr_rdata == $past(port0_pin_in))
    else $error("port 0 pin read wrong");
  p2_level_a: assert property (sfr_req.rd_s1 && sfr_req.addr == 6'h0d |=> sfr_rdata == {5'h00, $past(port2_pin_in)})
    else $error("port 2 pin read wrong");
  p0_drive_a: assert property (wr_s(6'h00) |=> ((port0_pin.out ^ $past(sfr_req.wdata)) & port0_pin.oe) == 8'h00
    && (port0_pin.oe | $past(sfr_req.wdata)) == 8'hff) else $error("port 0 drive wrong after write");
  p0_pushpull_a: assert property (wr_s(6'h0b) |=> (port0_pin.oe & $past(sfr_req.wdata)) == $past(sfr_req.wdata))
    else $error("push-pull bit not driven");
  p1_dir_a: assert property (wr_s(6'h09) |=> port1_pin.oe == ($past(sfr_req.wdata[2:0]) & {2'b11, ~ext_irq0_pin_select}))
    else $error("port 1 direction wrong");
  reset_pins_a: assert property ($fell(srst) |-> port0_pin.oe == 8'h00 && port1_pin.oe == 3'h0
    && port2_pin.oe[1:0] == 2'h0) else $error("pins driven after reset");
  stop_float_a: assert property (stop_mode |-> !port2_pin.oe[0])
    else $error("port 2 bit 0 driven in stop");
  dual_res_a: assert property (dual_clock_mode |-> !port2_pin.oe[1] && port2_pin.oe[2]
    && port2_pin.out[2] == slow_resonator_out && slow_resonator_in == port2_pin_in[1]) else $error("resonator pins wrong");
  irq0_sel_a: assert property (ext_irq0_pin_select ? !port1_pin.oe[0] : !ext_irq0_req)
    else $error("interrupt 0 select not honoured");
  irq0_edge_a: assert property (fall0_s |-> ext_irq0_req)
    else $error("interrupt 0 edge missed");
  irq1_edge_a: assert property (run_q == 2'b11 && $changed(port1_pin_in[1]) |=> port1_bit1_irq_req)
    else $error("port 1 bit 1 edge missed");
  irq2_edge_a: assert property (run_q == 2'b11 && $fell(port2_pin_in[0]) |=> port2_bit0_irq_req)
    else $error("port 2 bit 0 fall missed");
  hit_decode_a: assert property (sfr_hit == ((sfr_req.rd_s1 || sfr_req.wr_s2) &&
    sfr_req.addr inside {6'h00, 6'h01, 6'h02, 6'h09, 6'h0b, 6'h0c, 6'h0d})) else $error("register hit flag wrong");
endmodule
bind parallel_io_ports parallel_io_ports_properties u_props (.ref_clk, .srst, .sfr_req, .sfr_rdata, .sfr_rvalid,
  .sfr_hit, .ext_irq0_pin_select, .dual_clock_mode, .stop_mode, .port0_pin_in, .port0_pin, .port1_pin_in,
  .port1_pin, .port2_pin_in, .port2_pin, .slow_resonator_out, .slow_resonator_in, .ext_irq0_req,
  .port1_bit1_irq_req, .port2_bit0_irq_req);

//--- sim/pin_world.sv
// Board model around the ports: outside sources on undriven pins.
`timescale 1ns/1ps
module pin_world (
  // Drive from the block
  input  wire gpio_pkg::port0_drive_type port0_pin,
  input  wire gpio_pkg::port3_drive_type port1_pin,
  input  wire gpio_pkg::port3_drive_type port2_pin,
  // Levels that outside sources put on released pins
  input  wire logic [7:0]                ext0,
  input  wire logic [2:0]                ext1,
  input  wire logic [2:0]                ext2,
  // Resolved pin levels
  output logic [7:0]                     lvl0,
  output logic [2:0]                     lvl1,
  output logic [2:0]                     lvl2
);
  // Sources hold their level until the bench moves them, as no input copy is kept.
  assign lvl0 = (port0_pin.oe & port0_pin.out) | (~port0_pin.oe & ext0);
  assign lvl1 = (port1_pin.oe & port1_pin.out) | (~port1_pin.oe & ext1);
  assign lvl2 = (port2_pin.oe & port2_pin.out) | (~port2_pin.oe & ext2);
endmodule
